// >>> hdl/t1e1_path_frame_error_counters.v
// How it works
// - ESF: count failed CRC6 codewords on path
// - D4: count Ft bit errors on path
// - Fs errors added in D4 when enabled
// - T1 path counter halts on sync loss
// - E1: path counter counts CRC-4 errors
// - E1 path halts on FAS/CRC4 loss only
// - 16-bit counters, high byte at lower address
// - MULTIFRAMES_OUT_OF_SYNC mode counts out-of-sync multiframes
// - MULTIFRAMES_OUT_OF_SYNC mode keeps counting during sync loss
// - F-bit mode: Ft in D4, FPS in ESF
// - F-bit mode halts on sync loss
// - E1: frame counter counts errored FAS words
// - E1 frame counter halts on loss/search
// - Far-end counter idle in T1
// - Count E-bits equal zero with CRC-4
// - Far-end halts on FAS/CRC4 loss only
// - Periodic latch and clear, short or second
// - Manual rising edge latches and clears
// - Counters saturate, never roll over
`include "t1e1_counters_regs.vh"
`default_nettype none

module t1e1_path_frame_error_counters #(
  parameter [15:0] T1_SECOND_FRAMES = `T1_SECOND_FRAMES,
  parameter [15:0] E1_SECOND_FRAMES = `E1_SECOND_FRAMES
) (
  // Clock and reset
  input  wire        clk,
  input  wire        srst,
  // Mode and configuration
  input  wire        e1Mode,
  input  wire        esfFraming,
  input  wire        signaling_frame_error_enable,
  input  wire        out_of_sync_count_select,
  input  wire        update_interval_select,
  input  wire        accumulation_mode_select,
  input  wire        manual_update_trigger,
  // Framer events, one-cycle pulses
  input  wire        frameStrobe,
  input  wire        crc6Error,
  input  wire        ftError,
  input  wire        fsError,
  input  wire        fpsError,
  input  wire        multiframeStrobe,
  input  wire        crc4Error,
  input  wire        fasWordError,
  input  wire        eBitStrobe,
  input  wire        eBitValue,
  // Framer sync status
  input  wire        receive_sync_lost,
  input  wire        fasLost,
  input  wire        crc4MultiframeLost,
  input  wire        alignmentSearch,
  input  wire        crc4Multiframing,
  // Register read port
  input  wire [7:0]  readAddr,
  output reg  [7:0]  readData,
  // Latched counts
  output reg  [15:0] path_error_counter,
  output reg  [15:0] frame_sync_error_counter,
  output reg  [15:0] far_end_block_counter
);

  // ****************************************
  // Saturating increment
  // ****************************************
  function [15:0] satInc;
    input [15:0] value;
    input        hit;
    begin
      if (hit && value != `COUNT_MAX) begin
        satInc = value + `COUNT_ONE;
      end else begin
        satInc = value;
      end
    end
  endfunction

  // ****************************************
  // Counter slots
  // ****************************************
  localparam integer NUM_COUNTERS = 3;
  localparam integer COUNT_WIDTH  = 16;
  localparam integer BYTE_WIDTH   = 8;
  localparam integer PATH_IDX     = 0;
  localparam integer FRAME_IDX    = 1;
  localparam integer FAR_END_IDX  = 2;
  localparam [1:0]   SLOT_PATH    = 2'h0;
  localparam [1:0]   SLOT_FRAME   = 2'h1;
  localparam [1:0]   SLOT_FAR_END = 2'h2;
  localparam [1:0]   SLOT_NONE    = 2'h3;

  // ****************************************
  // Address decode
  // ****************************************
  // Counter that a read address belongs to
  function [1:0] addrSlot;
    input [7:0] addr;
    begin
      if (addr == `PATH_ERROR_COUNT_HIGH_ADDR) begin
        addrSlot = SLOT_PATH;
      end else if (addr == `PATH_ERROR_COUNT_LOW_ADDR) begin
        addrSlot = SLOT_PATH;
      end else if (addr == `FRAME_SYNC_ERROR_COUNT_HIGH_ADDR) begin
        addrSlot = SLOT_FRAME;
      end else if (addr == `FRAME_SYNC_ERROR_COUNT_LOW_ADDR) begin
        addrSlot = SLOT_FRAME;
      end else if (addr == `FAR_END_BLOCK_COUNT_HIGH_ADDR) begin
        addrSlot = SLOT_FAR_END;
      end else if (addr == `FAR_END_BLOCK_COUNT_LOW_ADDR) begin
        addrSlot = SLOT_FAR_END;
      end else begin
        addrSlot = SLOT_NONE;
      end
    end
  endfunction

  // High byte sits at the lower address of each pair
  function addrIsHigh;
    input [7:0] addr;
    begin
      if (addr == `PATH_ERROR_COUNT_HIGH_ADDR) begin
        addrIsHigh = 1'b1;
      end else if (addr == `FRAME_SYNC_ERROR_COUNT_HIGH_ADDR) begin
        addrIsHigh = 1'b1;
      end else if (addr == `FAR_END_BLOCK_COUNT_HIGH_ADDR) begin
        addrIsHigh = 1'b1;
      end else begin
        addrIsHigh = 1'b0;
      end
    end
  endfunction

  // ****************************************
  // Event qualification
  // ****************************************
  reg pathHit;
  reg frameHit;
  reg farEndHit;

  // Path counter: CRC errors, or framing bit errors under D4
  always @* begin
    pathHit = 1'b0;
    if (e1Mode) begin
      if (!fasLost && !crc4MultiframeLost) begin
        pathHit = crc4Error;
      end
    end else if (!receive_sync_lost) begin
      if (esfFraming) begin
        pathHit = crc6Error;
      end else if (signaling_frame_error_enable) begin
        pathHit = ftError || fsError;
      end else begin
        pathHit = ftError;
      end
    end
  end

  // Frame counter: FAS words in E1, lost multiframes or F-bit errors in T1
  always @* begin
    frameHit = 1'b0;
    if (e1Mode) begin
      if (!receive_sync_lost && !alignmentSearch) begin
        frameHit = fasWordError;
      end
    end else if (out_of_sync_count_select) begin
      frameHit = multiframeStrobe && receive_sync_lost;
    end else if (!receive_sync_lost) begin
      if (esfFraming) begin
        frameHit = fpsError;
      end else begin
        frameHit = ftError;
      end
    end
  end

  // Far-end counter: zero E-bits, E1 with CRC-4 multiframing only
  always @* begin
    farEndHit = 1'b0;
    if (!e1Mode) begin
      farEndHit = 1'b0;
    end else if (crc4Multiframing && !fasLost && !crc4MultiframeLost) begin
      farEndHit = eBitStrobe && !eBitValue;
    end
  end

  // Hits gathered by counter slot
  wire [NUM_COUNTERS-1:0] hitVec = {farEndHit, frameHit, pathHit};

  // ****************************************
  // Update timing
  // ****************************************
  reg [15:0] frameCount;
  reg [15:0] next_frameCount;
  reg        manualPrev;
  reg        manualRise;
  reg [15:0] shortLimit;
  reg [15:0] secondLimit;
  reg [15:0] limit;
  reg        lastFrame;
  reg        periodic;
  reg        manual;
  reg        update;

  // Interval length in frames for the current mode
  always @* begin
    if (e1Mode) begin
      shortLimit  = `E1_SHORT_FRAMES;
      secondLimit = E1_SECOND_FRAMES;
    end else begin
      shortLimit  = `T1_SHORT_FRAMES;
      secondLimit = T1_SECOND_FRAMES;
    end
    if (update_interval_select) begin
      limit = shortLimit;
    end else begin
      limit = secondLimit;
    end
  end

  // Manual bit edge; a bit left high never updates twice
  always @* begin
    manualRise = manual_update_trigger && !manualPrev;
  end

  // Update on the last frame of an interval or on a rising manual bit
  always @* begin
    lastFrame = (frameCount >= limit - `FRAME_ONE);
    periodic  = !accumulation_mode_select && frameStrobe && lastFrame;
    manual    = accumulation_mode_select && manualRise;
    update    = periodic || manual;
  end

  // Frame count is held at zero while manual updates are selected
  always @* begin
    next_frameCount = frameCount;
    if (periodic || accumulation_mode_select) begin
      next_frameCount = `FRAME_RESET;
    end else if (frameStrobe) begin
      next_frameCount = frameCount + `FRAME_ONE;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      frameCount <= `FRAME_RESET;
      manualPrev <= 1'b0;
    end else begin
      frameCount <= next_frameCount;
      manualPrev <= manual_update_trigger;
    end
  end

  // ****************************************
  // Accumulators
  // ****************************************
  wire [NUM_COUNTERS*COUNT_WIDTH-1:0] latchedVec = {far_end_block_counter,
                                                    frame_sync_error_counter,
                                                    path_error_counter};
  wire [NUM_COUNTERS*COUNT_WIDTH-1:0] nextLatchedVec;

  genvar slot;
  generate
    for (slot = 0; slot < NUM_COUNTERS; slot = slot + 1) begin : gen_counter
      reg [15:0] acc;
      reg [15:0] next_acc;
      reg [15:0] next_latched;

      // Event in the update cycle is kept in the latched value
      always @* begin
        next_acc     = satInc(acc, hitVec[slot]);
        next_latched = latchedVec[COUNT_WIDTH*slot +: COUNT_WIDTH];
        if (update) begin
          next_latched = next_acc;
          next_acc     = `COUNT_RESET;
        end
      end

      always @(posedge clk) begin
        if (srst) begin
          acc <= `COUNT_RESET;
        end else begin
          acc <= next_acc;
        end
      end

      assign nextLatchedVec[COUNT_WIDTH*slot +: COUNT_WIDTH] = next_latched;
    end
  endgenerate

  // ****************************************
  // Latched counts
  // ****************************************
  // Outputs are the latch flip-flops themselves
  always @(posedge clk) begin
    if (srst) begin
      path_error_counter       <= `COUNT_RESET;
      frame_sync_error_counter <= `COUNT_RESET;
      far_end_block_counter    <= `COUNT_RESET;
    end else begin
      path_error_counter       <= nextLatchedVec[COUNT_WIDTH*PATH_IDX +: COUNT_WIDTH];
      frame_sync_error_counter <= nextLatchedVec[COUNT_WIDTH*FRAME_IDX +: COUNT_WIDTH];
      far_end_block_counter    <= nextLatchedVec[COUNT_WIDTH*FAR_END_IDX +: COUNT_WIDTH];
    end
  end

  // ****************************************
  // Register read decode
  // ****************************************
  reg [1:0]  readSlot;
  reg [15:0] selCount;
  reg [7:0]  next_readData;

  always @* begin
    readSlot = addrSlot(readAddr);
    selCount = `COUNT_RESET;
    if (readSlot == SLOT_PATH) begin
      selCount = path_error_counter;
    end else if (readSlot == SLOT_FRAME) begin
      selCount = frame_sync_error_counter;
    end else if (readSlot == SLOT_FAR_END) begin
      selCount = far_end_block_counter;
    end
    next_readData = `REG_RESET;
    if (readSlot != SLOT_NONE) begin
      if (addrIsHigh(readAddr)) begin
        next_readData = selCount[COUNT_WIDTH-1:BYTE_WIDTH];
      end else begin
        next_readData = selCount[BYTE_WIDTH-1:0];
      end
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      readData <= `REG_RESET;
    end else begin
      readData <= next_readData;
    end
  end

endmodule // t1e1_path_frame_error_counters

`default_nettype wire

// >>> hdl/t1e1_counters_regs.vh
`ifndef T1E1_COUNTERS_REGS_VH
`define T1E1_COUNTERS_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define PATH_ERROR_COUNT_HIGH_ADDR       8'h44
`define PATH_ERROR_COUNT_LOW_ADDR        8'h45
`define FRAME_SYNC_ERROR_COUNT_HIGH_ADDR 8'h46
`define FRAME_SYNC_ERROR_COUNT_LOW_ADDR  8'h47
`define FAR_END_BLOCK_COUNT_HIGH_ADDR    8'h48
`define FAR_END_BLOCK_COUNT_LOW_ADDR     8'h49

// ****************************************
// Reset values and limits
// ****************************************
`define COUNT_RESET  16'h0000
`define COUNT_MAX    16'hFFFF
`define COUNT_ONE    16'h0001
`define REG_RESET    8'h00
`define FRAME_RESET  16'h0000
`define FRAME_ONE    16'h0001

// ****************************************
// Update intervals in frames
// ****************************************
`define T1_SHORT_FRAMES  16'd333
`define E1_SHORT_FRAMES  16'd500
`define T1_SECOND_FRAMES 16'd8000
`define E1_SECOND_FRAMES 16'd8000

`endif

// >>> bench/t1e1_framer_model.sv
`default_nettype none
module t1e1_framer_model (
  // Clock
  input  wire logic clk,
  // Frame timing
  output var  logic frameStrobe,
  output var  logic multiframeStrobe
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned n = 0;
  initial begin
    frameStrobe = 1'b0;
    multiframeStrobe = 1'b0;
  end
  // One frame every 4 clocks, one multiframe every 12 frames
  always @(negedge clk) begin
    n <= n + 1;
    frameStrobe <= (n % 4 == 3);
    multiframeStrobe <= (n % 48 == 47);
  end
endmodule // t1e1_framer_model
`default_nettype wire

// >>> bench/t1e1_counters_props.sv
`default_nettype none
module t1e1_counters_props (
  // Control
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        accumulation_mode_select,
  input wire logic        manual_update_trigger,
  // Read port and counts
  input wire logic [7:0]  readAddr,
  input wire logic [7:0]  readData,
  input wire logic [15:0] path_error_counter,
  input wire logic [15:0] frame_sync_error_counter,
  input wire logic [15:0] far_end_block_counter
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [15:0] pc = path_error_counter;
  wire [15:0] fc = frame_sync_error_counter;
  wire [15:0] fe = far_end_block_counter;
  wire [7:0]  a  = readAddr;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_reset_clears: assert property (disable iff (1'b0) srst |=> {pc, fc, fe} == 48'h0)
    else $error("counts not cleared by reset");
  a_hold_between: assert property (
    accumulation_mode_select && !$rose(manual_update_trigger) |=> $stable({pc, fc, fe}))
    else $error("latched counts changed without update");
  a_path_high: assert property (a == 8'h44 ##1 $stable(pc) |-> readData == pc[15:8])
    else $error("path high byte wrong");
  a_path_low: assert property (a == 8'h45 ##1 $stable(pc) |-> readData == pc[7:0])
    else $error("path low byte wrong");
  a_frame_high: assert property (a == 8'h46 ##1 $stable(fc) |-> readData == fc[15:8])
    else $error("frame high byte wrong");
  a_frame_low: assert property (a == 8'h47 ##1 $stable(fc) |-> readData == fc[7:0])
    else $error("frame low byte wrong");
  a_far_high: assert property (a == 8'h48 ##1 $stable(fe) |-> readData == fe[15:8])
    else $error("far-end high byte wrong");
  a_far_low: assert property (a == 8'h49 ##1 $stable(fe) |-> readData == fe[7:0])
    else $error("far-end low byte wrong");
  a_unmapped_zero: assert property (!(a inside {[8'h44:8'h49]}) |=> readData == 8'h00)
    else $error("unmapped read not zero");
endmodule // t1e1_counters_props
bind t1e1_path_frame_error_counters t1e1_counters_props props_u (.clk(clk), .srst(srst),
  .accumulation_mode_select(accumulation_mode_select),
  .manual_update_trigger(manual_update_trigger), .readAddr(readAddr), .readData(readData),
  .path_error_counter(path_error_counter), .frame_sync_error_counter(frame_sync_error_counter),
  .far_end_block_counter(far_end_block_counter));
`default_nettype wire

// >>> bench/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, srst = 1'b1, e1 = 1'b0, esf = 1'b1, sfe = 1'b1, oos = 1'b0, uis = 1'b0;
  logic ams = 1'b1, mut = 1'b0, ebv = 1'b0, rsl = 1'b0, fasl = 1'b0, srch = 1'b0, mf4 = 1'b1;
  logic mfl = 1'b0;
  logic [6:0] ev = 7'h00;
  logic [7:0] addr = 8'h00;
  wire logic frm, mfs;
  wire logic [7:0] rd;
  wire logic [15:0] pc, fc, fe;
  int n_fail = 0, comparisons = 0, mosN = 0;
  t1e1_framer_model far_u (.clk(clk), .frameStrobe(frm), .multiframeStrobe(mfs));
  t1e1_path_frame_error_counters #(.T1_SECOND_FRAMES(16'h000A), .E1_SECOND_FRAMES(16'h000A))
  dut_u (.clk(clk), .srst(srst), .e1Mode(e1), .esfFraming(esf),
    .signaling_frame_error_enable(sfe), .out_of_sync_count_select(oos),
    .update_interval_select(uis), .accumulation_mode_select(ams), .manual_update_trigger(mut),
    .frameStrobe(frm), .crc6Error(ev[0]), .ftError(ev[1]), .fsError(ev[2]), .fpsError(ev[3]),
    .multiframeStrobe(mfs), .crc4Error(ev[4]), .fasWordError(ev[5]), .eBitStrobe(ev[6]),
    .eBitValue(ebv), .receive_sync_lost(rsl), .fasLost(fasl), .crc4MultiframeLost(mfl),
    .alignmentSearch(srch), .crc4Multiframing(mf4), .readAddr(addr), .readData(rd),
    .path_error_counter(pc), .frame_sync_error_counter(fc), .far_end_block_counter(fe));
  initial forever #25 clk = ~clk;
  task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task pulse(input int i, input int n);
    repeat (n) begin
      @(negedge clk) ev[i] = 1'b1;
      @(negedge clk) ev[i] = 1'b0;
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk) addr = a;
    @(negedge clk);
    chk("readData", {8'h00, e}, {8'h00, rd});
  endtask
  task upd;
    @(negedge clk) mut = 1'b1;
    @(negedge clk) mut = 1'b0;
    @(negedge clk);
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    srst = 1'b0;
    for (int a = 8'h44; a <= 8'h4A; a++) rdchk(a[7:0], 8'h00);
    $display("reset test done");
    pulse(0, 3);
    pulse(3, 2);
    pulse(2, 1);
    rsl = 1'b1;
    pulse(0, 1);
    pulse(3, 1);
    rsl = 1'b0;
    upd;
    rdchk(8'h45, 8'h03);
    chk("frame", 16'h0002, fc);
    esf = 1'b0;
    pulse(1, 2);
    pulse(2, 1);
    upd;
    chk("path", 16'h0003, pc);
    chk("frame", 16'h0002, fc);
    oos = 1'b1;
    @(negedge clk) rsl = 1'b1;
    repeat (200) @(posedge clk) mosN += mfs;
    @(negedge clk) rsl = 1'b0;
    upd;
    chk("frame", mosN[15:0], fc);
    $display("t1 test done");
    e1 = 1'b1;
    pulse(4, 2);
    pulse(5, 1);
    pulse(6, 2);
    ebv = 1'b1;
    pulse(6, 1);
    ebv = 1'b0;
    fasl = 1'b1;
    pulse(4, 1);
    pulse(6, 1);
    fasl = 1'b0;
    srch = 1'b1;
    pulse(5, 1);
    srch = 1'b0;
    rsl = 1'b1;
    pulse(5, 1);
    rsl = 1'b0;
    mfl = 1'b1;
    pulse(4, 1);
    pulse(6, 1);
    mfl = 1'b0;
    mf4 = 1'b0;
    pulse(6, 1);
    mf4 = 1'b1;
    upd;
    chk("path", 16'h0002, pc);
    chk("frame", 16'h0001, fc);
    rdchk(8'h49, 8'h02);
    e1 = 1'b0;
    pulse(6, 2);
    upd;
    chk("far", 16'h0000, fe);
    $display("e1 test done");
    esf = 1'b1;
    uis = 1'b1;
    ams = 1'b0;
    pulse(0, 5);
    repeat (1340) @(negedge clk);
    chk("path", 16'h0005, pc);
    ams = 1'b1;
    upd;
    @(negedge clk) ev[0] = 1'b1;
    repeat (65540) @(negedge clk);
    ev[0] = 1'b0;
    upd;
    rdchk(8'h44, 8'hFF);
    rdchk(8'h45, 8'hFF);
    uis = 1'b0;
    ams = 1'b0;
    pulse(0, 2);
    repeat (45) @(negedge clk);
    chk("path", 16'h0002, pc);
    $display("update test done");
    print_verdict;
  end
  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    print_verdict;
  end
endmodule // tb
`default_nettype wire
